/* src/irq_ctrl.sv */
// Function
// R1 - no vectoring unless all call conditions hold; fresh poll every cycle
// R2 - denied requests are not remembered
// R3 - timer overflow flags clear on vectoring to them
// R4 - external flags clear on vectoring only in edge mode
// R5 - uart and watchdog flags untouched by vectoring
// R6 - hardware call pushes program counter only, not status word
// R7 - program counter loads the fixed vector of the source
// R8 - return-from-interrupt pops pc and ends current service level
// R9 - plain return pops pc but keeps service level
// R10 - level is high bit msb, low bit lsb; 00 lowest
// R11 - preempt only by strictly higher level; level 3 never preempted
// R12 - higher level request wins among simultaneous requests
// R13 - equal levels resolved by fixed rank
// R14 - enable/priority bit positions per source across two registers
// R15 - only listed sources wake from power-down
// R16 - conversion wake only when converter runs from internal rc
// R17 - external pins sampled at c3, flags polled next cycle
// R18 - call takes four machine cycles
// R19 - worst single latency twelve machine cycles, 48 clocks
// R20 - enabled external request wakes from power-down or idle
// R21 - no vectoring while equal or higher level in service
// R22 - vector only in last cycle, not after enable write or return
// R23 - master gate disables all sources
// R24 - one in-service bit per level; set on call, top cleared on return
`timescale 1ns/10ps
module irq_ctrl
	import irq_ctrl_pkg::*;
(
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_reset,
	input  wire logic                        i_ext_request_pin_a,
	input  wire logic                        i_ext_request_pin_b,
	input  wire logic                        i_ext_a_edge_mode,
	input  wire logic                        i_ext_b_edge_mode,
	input  wire logic                        i_timer_a_overflow,
	input  wire logic                        i_timer_b_overflow,
	input  wire logic [irq_ctrl_pkg::NUM_SRC-1:0] i_flag_set,
	input  wire logic [irq_ctrl_pkg::NUM_SRC-1:0] i_flag_clr,
	input  wire logic [6:0]                  i_enable_reg_a,
	input  wire logic [5:0]                  i_enable_reg_b,
	input  wire logic                        i_master_irq_gate,
	input  wire logic [6:0]                  i_prio_low_reg_a,
	input  wire logic [6:0]                  i_prio_high_reg_a,
	input  wire logic [5:0]                  i_prio_low_reg_b,
	input  wire logic [5:0]                  i_prio_high_reg_b,
	input  wire logic                        i_conv_on_rc,
	input  wire logic                        i_power_down,
	input  wire logic                        i_idle,
	input  wire irq_ctrl_pkg::seq_info_t     i_seq,
	output logic [irq_ctrl_pkg::NUM_SRC-1:0] o_flags,
	output logic                             o_call_req,
	output logic [15:0]                      o_call_vector,
	output logic [15:0]                      o_push_pc,
	output logic                             o_call_busy,
	output logic [3:0]                       o_in_service,
	output logic                             o_wake
);
	import irq_ctrl_pkg::*;

	// ************************************************************
	// machine cycle phase
	// ************************************************************
	logic [1:0]         phase_q;
	logic               mc_end;
	logic               pin_a_q, pin_b_q;
	logic [NUM_SRC-1:0] flag_q, flag_d;
	logic [NUM_SRC-1:0] enab, prio_h, prio_l, req;
	logic [3:0]         ins_q, ins_d;
	logic               win_ok;
	logic [3:0]         win_src;
	logic [1:0]         win_lvl;
	logic [1:0]         cur_lvl;
	logic               busy_lvl;
	logic [2:0]         call_cnt_q;
	call_state_t        state_q;
	logic               fire;
	logic [5:0]         lat_q;

	assign mc_end = (phase_q == 2'h3);

	// four clocks per machine cycle
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	// ************************************************************
	// flags
	// ************************************************************
	// second register carries sources 7 to 12, brake at its top bit
	assign enab   = {i_enable_reg_b,
		i_enable_reg_a}; // R14
	assign prio_h = {i_prio_high_reg_b,
		i_prio_high_reg_a}; // R14
	assign prio_l = {i_prio_low_reg_b,
		i_prio_low_reg_a}; // R14

	// next flag values; set wins over clear
	always_comb begin
		flag_d = flag_q & ~i_flag_clr;
		if (phase_q == PHASE_C3) begin
			// R17
			if (i_ext_a_edge_mode) begin
				if (pin_a_q && !i_ext_request_pin_a) flag_d[SRC_EXT0] = 1'b1;
			end else begin
				flag_d[SRC_EXT0] = ~i_ext_request_pin_a; // R4
			end
			if (i_ext_b_edge_mode) begin
				if (pin_b_q && !i_ext_request_pin_b) flag_d[SRC_EXT1] = 1'b1;
			end else begin
				flag_d[SRC_EXT1] = ~i_ext_request_pin_b; // R4
			end
		end
		// hardware clear on vectoring; uart/wdog untouched R5
		if (fire) begin
			if (win_src == 4'(SRC_TMRA)) flag_d[SRC_TMRA] = 1'b0; // R3
			if (win_src == 4'(SRC_TMRB)) flag_d[SRC_TMRB] = 1'b0; // R3
			if (win_src == 4'(SRC_EXT0) && i_ext_a_edge_mode)
				flag_d[SRC_EXT0] = 1'b0; // R4
			if (win_src == 4'(SRC_EXT1) && i_ext_b_edge_mode)
				flag_d[SRC_EXT1] = 1'b0; // R4
		end
		flag_d = flag_d | i_flag_set;
		if (phase_q == PHASE_C3) begin
			flag_d[SRC_TMRA] = flag_d[SRC_TMRA] | i_timer_a_overflow; // R17
			flag_d[SRC_TMRB] = flag_d[SRC_TMRB] | i_timer_b_overflow; // R17
		end
	end

	// flag registers and pin samples
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			flag_q  <= '0;
			pin_a_q <= 1'b1;
			pin_b_q <= 1'b1;
		end else begin
			flag_q <= flag_d;
			if (phase_q == PHASE_C3) begin
				pin_a_q <= i_ext_request_pin_a;
				pin_b_q <= i_ext_request_pin_b;
			end
		end
	end

	// ************************************************************
	// poll and arbitration
	// ************************************************************
	assign req = flag_q & enab & {NUM_SRC{i_master_irq_gate}}; // R23 R2

	// level then rank selection
	always_comb begin
		win_ok  = 1'b0;
		win_src = 4'h0;
		win_lvl = 2'h0;
		for (int l = NUM_LVL - 1; l >= 0; l--) begin
			for (int r = 0; r < NUM_SRC; r++) begin
				if (!win_ok && req[RANK[r]] &&
					{prio_h[RANK[r]], prio_l[RANK[r]]} == 2'(l)) begin // R10
					win_ok  = 1'b1; // R12 R13
					win_src = 4'(RANK[r]);
					win_lvl = 2'(l);
				end
			end
		end
	end

	// highest level in service
	always_comb begin
		busy_lvl = |ins_q;
		cur_lvl  = 2'h0;
		for (int l = 0; l < NUM_LVL; l++) begin
			if (ins_q[l]) cur_lvl = 2'(l);
		end
	end

	// call only when all conditions hold this machine cycle
	assign fire = mc_end && win_ok && state_q == ST_IDLE && i_seq.last_mc &&
		!i_seq.writes_ie && !i_seq.is_reti &&
		(!busy_lvl || win_lvl > cur_lvl); // R1 R21 R22 R11

	// clocks an eligible request waits with nothing in service
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			lat_q <= 6'h00;
		end else if (win_ok && !busy_lvl && state_q == ST_IDLE && !fire &&
			!i_power_down && !i_idle) begin
			if (lat_q != 6'h3f) lat_q <= lat_q + 6'h01; // R19
		end else begin
			lat_q <= 6'h00;
		end
	end

	// ************************************************************
	// in-service tracking
	// ************************************************************
	always_comb begin
		ins_d = ins_q;
		if (i_seq.is_reti && mc_end) begin
			if (ins_q[3]) ins_d[3] = 1'b0; // R24 R8
			else if (ins_q[2]) ins_d[2] = 1'b0;
			else if (ins_q[1]) ins_d[1] = 1'b0;
			else ins_d[0] = 1'b0;
		end
		// plain return leaves ins untouched R9
		if (fire) ins_d[win_lvl] = 1'b1; // R24
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			ins_q <= 4'h0;
		end else begin
			ins_q <= ins_d;
		end
	end

	// ************************************************************
	// hardware call sequence
	// ************************************************************
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			state_q       <= ST_IDLE;
			call_cnt_q    <= 3'h0;
			o_call_req    <= 1'b0;
			o_call_vector <= PC_RESET;
			o_push_pc     <= PC_RESET;
		end else begin
			o_call_req <= fire;
			unique case (state_q)
				ST_IDLE: begin
					if (fire) begin
						state_q       <= ST_CALL;
						call_cnt_q    <= 3'(CALL_MC); // R18
						o_call_vector <= VEC[win_src]; // R7
						o_push_pc     <= i_seq.pc; // R6
					end
				end
				ST_CALL: begin
					if (mc_end) begin
						if (call_cnt_q == 3'h1) state_q <= ST_IDLE; // R18
						call_cnt_q <= call_cnt_q - 3'h1;
					end
				end
			endcase
		end
	end

	// ************************************************************
	// outputs and wake
	// ************************************************************
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_flags      <= '0;
			o_in_service <= 4'h0;
			o_call_busy  <= 1'b0;
			o_wake       <= 1'b0;
		end else begin
			o_flags      <= flag_d;
			o_in_service <= ins_d;
			// drops on the edge that ends the fourth machine cycle
			o_call_busy  <= fire || (state_q == ST_CALL &&
				!(mc_end && call_cnt_q == 3'h1)); // R18
			o_wake <= (i_power_down &&
				|(req & WAKE_PD & ~({NUM_SRC{!i_conv_on_rc}} &
				(NUM_SRC'(1) << SRC_CONV)))) || // R15 R16
				(i_idle && |req) || // R20
				(i_power_down && |(req & (NUM_SRC'(1) << SRC_EXT0
				| NUM_SRC'(1) << SRC_EXT1))); // R20
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	property p_no_call_when_write;
		@(posedge i_ref_clk) disable iff (i_reset)
		(i_seq.writes_ie || i_seq.is_reti || !i_seq.last_mc) |=> !o_call_req;
	endproperty
	a_no_call_when_write: assert property (p_no_call_when_write) // R22
		else $error("call issued in blocked cycle");

	property p_no_preempt_top;
		@(posedge i_ref_clk) disable iff (i_reset)
		ins_q[3] && !i_seq.is_reti |=> !o_call_req;
	endproperty
	a_no_preempt_top: assert property (p_no_preempt_top) // R11
		else $error("level 3 routine preempted");

	property p_timer_clear;
		@(posedge i_ref_clk) disable iff (i_reset)
		fire && win_src == 4'(SRC_TMRA) && !i_flag_set[SRC_TMRA] &&
		!(phase_q == PHASE_C3 && i_timer_a_overflow) |=> !flag_q[SRC_TMRA];
	endproperty
	a_timer_clear: assert property (p_timer_clear) // R3
		else $error("timer flag not cleared on vectoring");

	property p_uart_kept;
		@(posedge i_ref_clk) disable iff (i_reset)
		fire && !i_flag_clr[SRC_UART] && flag_q[SRC_UART]
		|=> flag_q[SRC_UART];
	endproperty
	a_uart_kept: assert property (p_uart_kept) // R5
		else $error("uart flag cleared by vectoring");

	property p_call_length;
		@(posedge i_ref_clk) disable iff (i_reset)
		o_call_req |-> o_call_busy [*8];
	endproperty
	a_call_length: assert property (p_call_length) // R18
		else $error("call sequence too short");

	property p_vector_ext0;
		@(posedge i_ref_clk) disable iff (i_reset)
		fire && win_src == 4'(SRC_EXT0) |=> o_call_vector == 16'h0003;
	endproperty
	a_vector_ext0: assert property (p_vector_ext0) // R7
		else $error("wrong vector for ext0");

	property p_gate_off;
		@(posedge i_ref_clk) disable iff (i_reset)
		!i_master_irq_gate |=> !o_call_req;
	endproperty
	a_gate_off: assert property (p_gate_off) // R23
		else $error("call with master gate off");

	property p_ret_keeps;
		@(posedge i_ref_clk) disable iff (i_reset)
		i_seq.is_ret && !i_seq.is_reti && !fire |=> ins_q == $past(ins_q);
	endproperty
	a_ret_keeps: assert property (p_ret_keeps) // R9
		else $error("plain return changed service state");

	property p_latency;
		@(posedge i_ref_clk) disable iff (i_reset)
		lat_q < 6'(MAX_LAT_CLK);
	endproperty
	a_latency: assert property (p_latency) // R19
		else $error("request waited beyond worst-case latency");

	property p_level_follow;
		@(posedge i_ref_clk) disable iff (i_reset)
		phase_q == PHASE_C3 && !i_ext_a_edge_mode && !i_flag_set[SRC_EXT0]
		|=> flag_q[SRC_EXT0] == !$past(i_ext_request_pin_a);
	endproperty
	a_level_follow: assert property (p_level_follow) // R4
		else $error("level mode flag not following pin");

	property p_service_mark;
		@(posedge i_ref_clk) disable iff (i_reset)
		fire |=> ins_q[$past(win_lvl)];
	endproperty
	a_service_mark: assert property (p_service_mark) // R24
		else $error("in-service bit not set on call");

	c_call: cover property (@(posedge i_ref_clk) o_call_req);
	c_nest: cover property (@(posedge i_ref_clk) ins_q[0] && ins_q[2]);
	c_wake: cover property (@(posedge i_ref_clk) o_wake);
	c_reti: cover property (@(posedge i_ref_clk)
		i_seq.is_reti && mc_end && |ins_q);
	c_block: cover property (@(posedge i_ref_clk)
		mc_end && win_ok && i_seq.writes_ie);
endmodule

/* src/irq_ctrl_pkg.sv */
package irq_ctrl_pkg;

	// ************************************************************
	// source indices, in enable/priority bit order
	// ************************************************************
	localparam int NUM_SRC   = 13;
	localparam int NUM_LVL   = 4;
	localparam int SRC_EXT0  = 0;
	localparam int SRC_TMRA  = 1;
	localparam int SRC_EXT1  = 2;
	localparam int SRC_TMRB  = 3;
	localparam int SRC_UART  = 4;
	localparam int SRC_BROWN = 5;
	localparam int SRC_CONV  = 6;
	localparam int SRC_TWI   = 7;
	localparam int SRC_KEYP  = 8;
	localparam int SRC_CMPA  = 9;
	localparam int SRC_CMPB  = 10;
	localparam int SRC_WDOG  = 11;
	localparam int SRC_BRAKE = 12;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int          CLK_PER_MC   = 4;
	localparam logic [1:0]  PHASE_C3     = 2'h2;
	localparam int          CALL_MC      = 4;
	localparam int          MAX_LAT_MC   = 12;
	localparam int          MAX_LAT_CLK  = MAX_LAT_MC * CLK_PER_MC;
	localparam logic [15:0] PC_RESET     = 16'h0000;
	localparam logic [1:0]  LVL_TOP      = 2'h3;

	// vector per source, indexed by source number
	localparam logic [15:0] VEC [NUM_SRC] = '{
		16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
		16'h005b, 16'h0033, 16'h003b, 16'h0063, 16'h0043, 16'h0053,
		16'h0073};

	// arbitration order, first entry wins ties
	localparam int RANK [NUM_SRC] = '{
		SRC_EXT0, SRC_BROWN, SRC_WDOG, SRC_TMRA, SRC_TWI, SRC_CONV,
		SRC_EXT1, SRC_KEYP, SRC_CMPA, SRC_TMRB, SRC_CMPB, SRC_UART,
		SRC_BRAKE};

	// sources able to wake from power-down
	localparam logic [NUM_SRC-1:0] WAKE_PD = 13'h0765;

	// ************************************************************
	// sequencer handshake
	// ************************************************************
	typedef struct packed {
		logic last_mc;     // last machine cycle of instruction
		logic writes_ie;   // instruction writes enable/priority
		logic is_reti;     // return-from-interrupt executing
		logic is_ret;      // plain subroutine return executing
		logic [15:0] pc;   // current program counter
	} seq_info_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CALL = 2'b01
	} call_state_t;

endpackage

/* dv/seq_model.sv */
`timescale 1ns/10ps
module seq_model (
	input  wire logic               i_ref_clk,
	input  wire logic               i_reset,
	input  wire logic               i_reti_req,
	input  wire logic               i_ret_req,
	input  wire logic               i_wie_req,
	input  wire logic               i_slow,
	input  wire logic               i_stall,
	output irq_ctrl_pkg::seq_info_t o_seq
);
	import irq_ctrl_pkg::*;
	// ****************************************
	// instruction sequencer stand-in
	// ****************************************
	logic [1:0] ph_q;
	logic [1:0] mc_q;
	logic [2:0] pend_q;
	logic       lst;
	logic [2:0] req;
	// last machine cycle each cycle unless stalled, or every third when slow
	assign lst = !i_stall && (!i_slow || mc_q == 2'h2);
	assign req = {i_reti_req, i_ret_req, i_wie_req};
	// phase, pending returns and writes, per-cycle info
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			ph_q   <= 2'h0;
			mc_q   <= 2'h0;
			pend_q <= 3'h0;
			o_seq  <= '0;
		end else begin
			ph_q   <= ph_q + 2'h1;
			pend_q <= pend_q | req;
			if (ph_q == 2'h2) begin
				o_seq.pc <= o_seq.pc + 16'h0001; // steady over the poll
			end
			if (ph_q == 2'h3) begin
				mc_q            <= lst ? 2'h0 : mc_q + 2'h1;
				o_seq.last_mc   <= lst;
				o_seq.is_reti   <= lst & pend_q[2];
				o_seq.is_ret    <= lst & pend_q[1];
				o_seq.writes_ie <= lst & pend_q[0];
				pend_q          <= lst ? req : pend_q | req;
			end
		end
	end
endmodule

/* dv/tb.sv */
`timescale 1ns/10ps
module tb;
	import irq_ctrl_pkg::*;
	// ****************************************
	// reference tables and bench signals
	// ****************************************
	localparam logic [15:0] VT [13] = '{16'h0003, 16'h000b, 16'h0013,
		16'h001b, 16'h0023, 16'h002b, 16'h005b, 16'h0033, 16'h003b,
		16'h0063, 16'h0043, 16'h0053, 16'h0073};
	localparam int RK [13] = '{0, 5, 11, 1, 7, 6, 2, 8, 9, 3, 10, 4, 12};
	localparam logic [12:0] WK = 13'h0765;
	logic        ref_clk, reset, pin_a, pin_b, edge_a, edge_b, ovf_a, ovf_b;
	logic        gate, on_rc, pdown, idle, reti, ret, wie, slow, stall;
	logic        call, busy, wake, got;
	logic [12:0] fset, fclr, flags, mf, en, phi, plo;
	logic [15:0] vec, ppc;
	logic [3:0]  insvc;
	logic [31:0] x;
	seq_info_t   seq;
	int          n_errors, samples_checked, seed, w, n, lq[$];

	irq_ctrl i_irq_ctrl (.i_ref_clk(ref_clk), .i_reset(reset),
		.i_ext_request_pin_a(pin_a), .i_ext_request_pin_b(pin_b),
		.i_ext_a_edge_mode(edge_a), .i_ext_b_edge_mode(edge_b),
		.i_timer_a_overflow(ovf_a), .i_timer_b_overflow(ovf_b),
		.i_flag_set(fset), .i_flag_clr(fclr), .i_enable_reg_a(en[6:0]),
		.i_enable_reg_b(en[12:7]), .i_master_irq_gate(gate),
		.i_prio_low_reg_a(plo[6:0]), .i_prio_high_reg_a(phi[6:0]),
		.i_prio_low_reg_b(plo[12:7]), .i_prio_high_reg_b(phi[12:7]),
		.i_conv_on_rc(on_rc), .i_power_down(pdown), .i_idle(idle),
		.i_seq(seq), .o_flags(flags), .o_call_req(call),
		.o_call_vector(vec), .o_push_pc(ppc), .o_call_busy(busy),
		.o_in_service(insvc), .o_wake(wake));
	seq_model i_seq_model (.i_ref_clk(ref_clk), .i_reset(reset),
		.i_reti_req(reti), .i_ret_req(ret), .i_wie_req(wie),
		.i_slow(slow), .i_stall(stall), .o_seq(seq));

	// 10 mhz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// ****************************************
	// reference model and checking
	// ****************************************
	task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
		samples_checked++;
		if (got_v !== exp_v) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got_v, exp_v);
		end
	endtask

	task automatic stop_test;
		$display("mismatches %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	function automatic int lvl(input int s);
		return {phi[s], plo[s]};
	endfunction

	// winner: highest level above service, then fixed rank
	function automatic int pick();
		int best, bl, top;
		best = -1;
		bl = -1;
		top = lq.size() > 0 ? lq[$] : -1;
		for (int k = 0; k < 13; k++) begin
			if (gate && mf[RK[k]] && en[RK[k]] && lvl(RK[k]) > top
				&& lvl(RK[k]) > bl) begin
				best = RK[k];
				bl = lvl(RK[k]);
			end
		end
		return best;
	endfunction

	function automatic logic [3:0] isv();
		logic [3:0] v;
		v = '0;
		foreach (lq[i]) v[lq[i]] = 1'b1;
		return v;
	endfunction

	// ****************************************
	// stimulus
	// ****************************************
	initial begin
		n_errors = 0;
		samples_checked = 0;
		seed = 32'h2019;
		{pin_a, pin_b, edge_a, edge_b, reset} = 5'h1f;
		{ovf_a, ovf_b, gate, on_rc, pdown, idle, reti, ret, wie} = '0;
		{slow, stall, fset, fclr, mf, en, phi, plo} = '0;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#1 chk({flags, call, busy, wake}, 16'h0000);
		// random rounds; first four use pins and overflows
		for (int r = 0; r < 80; r++) begin
			x = $random(seed);
			@(posedge ref_clk);
			gate <= 1'b0; // no call while the round is being set up
			if (x[1:0] == 2'h0 && lq.size() > 0) begin
				reti <= 1'b1;
				void'(lq.pop_back());
			end
			ret <= x[1:0] == 2'h1;
			slow <= x[2];
			fclr <= {13{x[4]}};
			fset <= x[17:5];
			mf = (x[4] ? 13'h0 : mf) | x[17:5];
			en <= x[30:18] | (13'h1 << r);
			x = $random(seed);
			{phi, plo} <= x[25:0];
			{pin_a, ovf_a, pin_b, ovf_b} <= {r != 0, r == 1, r != 2, r == 3};
			@(posedge ref_clk);
			{reti, ret, fset, fclr} <= '0;
			repeat (4) @(posedge ref_clk);
			{pin_a, pin_b, ovf_a, ovf_b} <= 4'hc;
			if (r < 4) mf[r] = 1'b1;
			repeat (20) @(posedge ref_clk);
			#1 chk(insvc, isv());
			gate <= r < 4 || x[31:29] != 3'h0;
			wie <= x[28];
			@(posedge ref_clk);
			#1 w = pick();
			wie <= 1'b0;
			got = call === 1'b1; // call may land on the first poll edge
			for (int i = 0; i < 100 && !got; i++) begin
				@(posedge ref_clk);
				#1 got = call === 1'b1;
			end
			if (w < 0) begin
				chk(got, 1'b0);
			end else begin
				chk(got, 1'b1);
				if (!got) stop_test();
				gate <= 1'b0;
				chk(vec, VT[w]);
				chk(ppc, seq.pc);
				lq.push_back(lvl(w));
				if (w < 4) mf[w] = 1'b0;
				n = 0;
				while (busy !== 1'b0 && n < 40) begin
					@(posedge ref_clk);
					#1 n++;
				end
				chk(n, 16);
				if (busy !== 1'b0) stop_test();
				chk(flags, mf);
				chk(insvc, isv());
			end
		end
		// level mode: flag follows the inverted pin
		{gate, stall} <= 2'h1;
		edge_a <= 1'b0;
		pin_a <= 1'b0;
		repeat (8) @(posedge ref_clk);
		#1 chk(flags[0], 1'b1);
		pin_a <= 1'b1;
		repeat (8) @(posedge ref_clk);
		#1 chk(flags[0], 1'b0);
		// wake from power-down and idle, one source at a time
		{stall, gate, edge_a} <= 3'h7;
		for (int s = 0; s < 39; s++) begin
			x = $random(seed);
			w = s < 26 ? s / 2 : s - 26;
			@(posedge ref_clk);
			{fclr, fset} <= {13'h1fff, 13'h0001 << w};
			{pdown, idle, on_rc} <= {s < 26, s >= 26, s[0]};
			en <= x[12:0];
			@(posedge ref_clk);
			{fclr, fset} <= '0;
			repeat (8) @(posedge ref_clk);
			#1 chk(wake, x[w] && (s >= 26 || WK[w] && (w != 6 || s[0])));
		end
		stop_test();
	end
endmodule
